// *** common/adcseq_pkg.sv ***
package adcseq_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int INSTR_NS    = 80;
  localparam int INSTR_CYC   = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RC_TAD_NS   = 4000;
  localparam int RC_TAD_CYC  = (RC_TAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_TADS   = 11;
  localparam int ABORT_TADS  = 2;
  localparam int RES_BITS    = 10;
  localparam int DIV_MIN     = 2;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [AW-1:0] IDX_RES_HI = 8'h1E;
  localparam logic [AW-1:0] IDX_CTRL   = 8'h1F;
  localparam logic [AW-1:0] IDX_ANALOG_PIN_SELECT  = 8'h91;
  localparam logic [AW-1:0] IDX_RES_LO = 8'h9E;
  localparam logic [AW-1:0] IDX_CLKCFG = 8'h9F;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_JUSTIFY = 7;
  localparam int CTRL_REF     = 6;
  localparam int CTRL_UNUSED  = 5;
  localparam int CTRL_CHS_LSB = 2;
  localparam int CTRL_GO      = 1;
  localparam int CTRL_EN      = 0;
  localparam int CLK_SEL_LSB  = 4;

  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [2:0] CLKSEL_RST = 3'h0;
  localparam logic [7:0] ANALOG_PIN_SELECT_RST  = 8'hFF;
  localparam logic [1:0] RC_CODE    = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_RCWAIT = 4'h2,
    ST_CONV   = 4'h4,
    ST_ABORT  = 4'h8
  } adcseq_state_t;

  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [DW-1:0] writedata;
    logic [3:0]    byteenable;
  } adcseq_avs_req_t;

  typedef struct packed {
    logic [DW-1:0] readdata;
    logic          waitrequest;
  } adcseq_avs_rsp_t;

  typedef struct packed {
    adcseq_state_t state;
    logic          justify;
    logic          ref_ext;
    logic [2:0]    channel_sel;
    logic          go;
    logic          enable;
    logic          powered;
    logic [2:0]    clk_sel;
    logic [7:0]    analog_pin_select;
    logic [7:0]    res_hi;
    logic [7:0]    res_lo;
    logic [9:0]    trial;
    logic [3:0]    tad_cnt;
    logic [3:0]    delay_cnt;
    logic          restart;
    logic          sleep_off;
    logic          done;
    logic          wake;
    logic          sample_hold;
    logic          cmp_meta;
    logic          cmp_sync;
    logic          bus_wait;
    logic [DW-1:0] rdata;
  } adcseq_regs_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } adcseq_tick_regs_t;

endpackage

// *** design/adcseq_tad_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

module adcseq_tad_gen #(
  parameter int RC_CYC = adcseq_pkg::RC_TAD_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [2:0] clk_sel,
  input  wire logic       restart,
  output logic            tick
);

  adcseq_pkg::adcseq_tick_regs_t st;
  adcseq_pkg::adcseq_tick_regs_t next_st;
  logic [15:0]                   div;

  // ----------------------------------------------------------------
  // Divider: x11 picks the RC period, else 2, 8, 32 doubled by bit 2
  // ----------------------------------------------------------------
  always_comb begin
    if (clk_sel[1:0] == adcseq_pkg::RC_CODE) begin
      div = 16'(RC_CYC);
    end else begin
      div = 16'(adcseq_pkg::DIV_MIN) << (2 * clk_sel[1:0] + {1'b0, clk_sel[2]});
    end
  end

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (restart) begin
      next_st.cnt = 16'h0000;
    end else if (st.cnt >= div - 16'h0001) begin
      next_st.cnt  = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
    if (!rst_n) begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign tick = st.tick;

endmodule

`default_nettype wire

// *** design/adcseq_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - justify bit one right, zero left
// - reference bit set selects external reference pin
// - channel field routes input index to hold
// - go starts conversion, hardware clears when done
// - enable bit powers converter, clear shuts off
// - clock field picks divider or internal RC
// - analog pin bits, all reset to one
// - analog pin disables input, pull-up, change-interrupt
// - hold capacitor never discharged between conversions
// - sleep conversion only RC, one instruction delay
// - sleep completion wakes or powers module off
// - sleep with divider clock aborts, powers off
// - reset aborts, turns off, keeps results
// - reset clears control and clock select
// - unimplemented bits always read zero
// - completion clears go, sets done flag
// - conversion lasts eleven conversion clock periods
// - abort keeps result, two-period delay, reacquire
module adcseq_top #(
  parameter int RC_CYC = adcseq_pkg::RC_TAD_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire adcseq_pkg::adcseq_avs_req_t avs_req,
  output adcseq_pkg::adcseq_avs_rsp_t      avs_rsp,
  input  wire logic                        sleep_mode,
  input  wire logic                        conv_int_en,
  input  wire logic                        cmp_in,
  output logic                             analog_on,
  output logic                             ref_ext,
  output logic [2:0]                       channel_route,
  output logic                             sample_hold,
  output logic [9:0]                       sar_trial,
  output logic [7:0]                       digin_off,
  output logic [7:0]                       pullup_off,
  output logic [7:0]                       ioc_off,
  output logic                             done_set,
  output logic                             wake_req
);

  adcseq_pkg::adcseq_regs_t st;
  adcseq_pkg::adcseq_regs_t next_st;
  logic                     tick;
  logic                     rc_sel;
  logic                     busy;
  logic                     wr_ack;
  logic                     ctrl_wr;
  logic [7:0]               wbyte;
  logic [3:0]               bit_pos;
  logic                     conv_tick;

  // ----------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------
  adcseq_tad_gen #(
    .RC_CYC (RC_CYC)
  ) u_tad (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .clk_sel (st.clk_sel),
    .restart (st.restart),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_view(input adcseq_pkg::adcseq_regs_t s,
                                          input logic [adcseq_pkg::AW-1:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      adcseq_pkg::IDX_CTRL: begin
        v = {s.justify, s.ref_ext, 1'b0, s.channel_sel, s.go, s.enable};
      end
      adcseq_pkg::IDX_CLKCFG: begin
        v = {1'b0, s.clk_sel, 4'h0};
      end
      adcseq_pkg::IDX_ANALOG_PIN_SELECT: begin
        v = s.analog_pin_select;
      end
      adcseq_pkg::IDX_RES_HI: begin
        v = s.res_hi;
      end
      adcseq_pkg::IDX_RES_LO: begin
        v = s.res_lo;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  assign rc_sel  = (st.clk_sel[1:0] == adcseq_pkg::RC_CODE);
  assign busy    = (st.state == adcseq_pkg::ST_RCWAIT) || (st.state == adcseq_pkg::ST_CONV);
  assign wr_ack  = avs_req.write && !st.bus_wait && avs_req.byteenable[0];
  assign ctrl_wr = wr_ack && (avs_req.address == adcseq_pkg::IDX_CTRL);
  assign wbyte   = avs_req.writedata[7:0];
  assign bit_pos = 4'(adcseq_pkg::RES_BITS) - st.tad_cnt;
  // A tick already launched when the divider restarts is stale: drop it
  assign conv_tick = tick && !st.restart;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st         = st;
    next_st.restart = 1'b0;
    next_st.done    = 1'b0;
    next_st.wake    = 1'b0;
    next_st.cmp_meta = cmp_in;
    next_st.cmp_sync = st.cmp_meta;

    // Bus handshake: one wait cycle, then the answer for one cycle
    if ((avs_req.read || avs_req.write) && st.bus_wait) begin
      next_st.bus_wait = 1'b0;
      next_st.rdata    = '0;
      if (avs_req.read) begin
        next_st.rdata[7:0] = reg_view(st, avs_req.address);
      end
    end else begin
      next_st.bus_wait = 1'b1;
    end

    // Register writes other than the control register
    if (wr_ack && avs_req.address == adcseq_pkg::IDX_CLKCFG) begin
      next_st.clk_sel = wbyte[adcseq_pkg::CLK_SEL_LSB +: 3];
    end
    if (wr_ack && avs_req.address == adcseq_pkg::IDX_ANALOG_PIN_SELECT) begin
      next_st.analog_pin_select = wbyte;
    end

    if (ctrl_wr) begin
      next_st.justify     = wbyte[adcseq_pkg::CTRL_JUSTIFY];
      next_st.ref_ext     = wbyte[adcseq_pkg::CTRL_REF];
      next_st.channel_sel = wbyte[adcseq_pkg::CTRL_CHS_LSB +: 3];
      next_st.enable      = wbyte[adcseq_pkg::CTRL_EN];
    end

    // Sleep power-off lasts until sleep ends
    if (!sleep_mode) begin
      next_st.sleep_off = 1'b0;
    end

    case (st.state)
      adcseq_pkg::ST_IDLE: begin
        if (ctrl_wr && wbyte[adcseq_pkg::CTRL_GO] && st.enable &&
            wbyte[adcseq_pkg::CTRL_EN] && !(sleep_mode && !rc_sel)) begin
          next_st.go = 1'b1;
          if (rc_sel) begin
            next_st.state     = adcseq_pkg::ST_RCWAIT;
            next_st.delay_cnt = 4'h0;
          end else begin
            next_st.state   = adcseq_pkg::ST_CONV;
            next_st.tad_cnt = 4'h0;
            next_st.restart = 1'b1;
          end
        end
      end
      adcseq_pkg::ST_RCWAIT: begin
        if (st.delay_cnt == 4'(adcseq_pkg::INSTR_CYC - 1)) begin
          next_st.state   = adcseq_pkg::ST_CONV;
          next_st.tad_cnt = 4'h0;
          next_st.restart = 1'b1;
        end else begin
          next_st.delay_cnt = st.delay_cnt + 4'h1;
        end
      end
      adcseq_pkg::ST_CONV: begin
        if (conv_tick) begin
          next_st.tad_cnt = st.tad_cnt + 4'h1;
          if (st.tad_cnt == 4'h0) begin
            next_st.trial = 10'h200;
          end else begin
            next_st.trial[bit_pos] = st.cmp_sync;
            if (bit_pos != 4'h0) begin
              next_st.trial[bit_pos - 4'h1] = 1'b1;
            end
          end
          if (st.tad_cnt == 4'(adcseq_pkg::CONV_TADS - 1)) begin
            next_st.state = adcseq_pkg::ST_IDLE;
            next_st.go    = 1'b0;
            next_st.done  = 1'b1;
            // Both result bytes load at the same edge
            if (st.justify) begin
              next_st.res_hi = {6'h00, next_st.trial[9:8]};
              next_st.res_lo = next_st.trial[7:0];
            end else begin
              next_st.res_hi = next_st.trial[9:2];
              next_st.res_lo = {next_st.trial[1:0], 6'h00};
            end
            if (sleep_mode) begin
              if (conv_int_en) begin
                next_st.wake = 1'b1;
              end else begin
                next_st.sleep_off = 1'b1;
              end
            end
          end
        end
      end
      adcseq_pkg::ST_ABORT: begin
        if (conv_tick) begin
          next_st.tad_cnt = st.tad_cnt + 4'h1;
          if (st.tad_cnt == 4'(adcseq_pkg::ABORT_TADS - 1)) begin
            next_st.state = adcseq_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        next_st.state = adcseq_pkg::ST_IDLE;
      end
    endcase

    // Software abort: results untouched, settle before reacquiring
    if (busy && ctrl_wr && !wbyte[adcseq_pkg::CTRL_GO]) begin
      next_st.go      = 1'b0;
      next_st.state   = adcseq_pkg::ST_ABORT;
      next_st.tad_cnt = 4'h0;
      next_st.restart = 1'b1;
    end

    // Divider clock stops in sleep: abort and power off, enable kept
    if (sleep_mode && !rc_sel) begin
      next_st.sleep_off = 1'b1;
      if (st.state != adcseq_pkg::ST_IDLE) begin
        next_st.go    = 1'b0;
        next_st.state = adcseq_pkg::ST_IDLE;
      end
    end

    // Clearing the enable drops any conversion in flight
    if (!next_st.enable) begin
      next_st.go    = 1'b0;
      next_st.state = adcseq_pkg::ST_IDLE;
    end

    next_st.powered     = next_st.enable && !next_st.sleep_off;
    // Hold switch only opens; the capacitor keeps its charge
    next_st.sample_hold = next_st.powered &&
                          (next_st.state == adcseq_pkg::ST_IDLE ||
                           next_st.state == adcseq_pkg::ST_RCWAIT);

    // Reset: control back to defaults, results kept
    if (!rst_n) begin
      next_st             = '0;
      next_st.state       = adcseq_pkg::ST_IDLE;
      next_st.justify     = adcseq_pkg::CTRL_RST[adcseq_pkg::CTRL_JUSTIFY];
      next_st.ref_ext     = adcseq_pkg::CTRL_RST[adcseq_pkg::CTRL_REF];
      next_st.channel_sel = adcseq_pkg::CTRL_RST[adcseq_pkg::CTRL_CHS_LSB +: 3];
      next_st.go          = adcseq_pkg::CTRL_RST[adcseq_pkg::CTRL_GO];
      next_st.enable      = adcseq_pkg::CTRL_RST[adcseq_pkg::CTRL_EN];
      next_st.clk_sel     = adcseq_pkg::CLKSEL_RST;
      next_st.analog_pin_select       = adcseq_pkg::ANALOG_PIN_SELECT_RST;
      next_st.bus_wait    = 1'b1;
      next_st.res_hi      = st.res_hi;
      next_st.res_lo      = st.res_lo;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_rsp.readdata    = st.rdata;
  assign avs_rsp.waitrequest = st.bus_wait;
  assign analog_on           = st.powered;
  assign ref_ext             = st.ref_ext;
  assign channel_route       = st.channel_sel;
  assign sample_hold         = st.sample_hold;
  assign sar_trial           = st.trial;
  assign digin_off           = st.analog_pin_select;
  assign pullup_off          = st.analog_pin_select;
  assign ioc_off             = st.analog_pin_select;
  assign done_set            = st.done;
  assign wake_req            = st.wake;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] chk_conv_ticks;
  logic [3:0] chk_abort_ticks;

  always_ff @(posedge mclk) begin
    if (st.state != adcseq_pkg::ST_CONV) begin
      chk_conv_ticks <= 4'h0;
    end else if (conv_tick) begin
      chk_conv_ticks <= chk_conv_ticks + 4'h1;
    end
    if (st.state != adcseq_pkg::ST_ABORT) begin
      chk_abort_ticks <= 4'h0;
    end else if (conv_tick) begin
      chk_abort_ticks <= chk_abort_ticks + 4'h1;
    end
  end

  a_done_clears_go: assert property (
    @(posedge mclk) disable iff (!rst_n) st.done |-> (!st.go && $past(st.go)))
    else $error("done flag raised without go falling");

  a_conv_length: assert property (
    @(posedge mclk) disable iff (!rst_n) st.done |-> (chk_conv_ticks == 4'hB))
    else $error("conversion did not last eleven clock periods");

  a_abort_delay: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ($past(st.state) == adcseq_pkg::ST_ABORT && st.state == adcseq_pkg::ST_IDLE &&
     st.enable && !st.sleep_off) |-> (chk_abort_ticks == 4'h2))
    else $error("abort delay not two clock periods");

  a_abort_keeps: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st.state == adcseq_pkg::ST_ABORT) |=> ($stable(st.res_hi) && $stable(st.res_lo)))
    else $error("result changed during abort");

  a_reset_ctrl: assert property (
    @(posedge mclk) !rst_n |=> (!st.go && !st.enable && !st.justify &&
                                st.clk_sel == 3'h0 && st.analog_pin_select == 8'hFF))
    else $error("control registers not at reset values");

  a_reset_result: assert property (
    @(posedge mclk) !rst_n |=> ($stable(st.res_hi) && $stable(st.res_lo) && !analog_on))
    else $error("reset disturbed result or left converter on");

  a_justify_right: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st.done && st.justify) |-> (st.res_hi[7:2] == 6'h00))
    else $error("right justified result has high bits set");

  a_justify_left: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (st.done && !st.justify) |-> (st.res_lo[5:0] == 6'h00))
    else $error("left justified result has low bits set");

  a_rc_delay: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(st.state == adcseq_pkg::ST_RCWAIT) |-> ##4 (st.state != adcseq_pkg::ST_RCWAIT))
    else $error("internal RC start delay overran");

  a_sleep_abort: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (sleep_mode && !rc_sel && st.state == adcseq_pkg::ST_CONV && rst_n) |=>
    (st.state == adcseq_pkg::ST_IDLE && !st.go && !analog_on))
    else $error("sleep did not abort divider clocked conversion");

  a_go_enabled: assert property (
    @(posedge mclk) disable iff (!rst_n) st.go |-> st.enable)
    else $error("conversion running with converter disabled");

  a_upper_zero: assert property (
    @(posedge mclk) disable iff (!rst_n) (st.rdata[31:8] == 24'h000000))
    else $error("read data above the low byte not zero");

endmodule

`default_nettype wire

// *** verif/adcseq_analog_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module adcseq_analog_model (
  input  wire logic            mclk,
  input  wire logic [2:0]      channel_route,
  input  wire logic            sample_hold,
  input  wire logic            analog_on,
  input  wire logic [9:0]      sar_trial,
  input  wire logic [7:0][9:0] levels,
  output logic                 cmp_in
);
  logic [9:0] held;

  initial held = 10'h000;

  // Hold capacitor follows the routed input while the switch is closed or the converter is off
  always @(posedge mclk) begin
    if (sample_hold || !analog_on) begin
      held <= levels[channel_route];
    end
  end

  assign cmp_in = (held >= sar_trial);
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end

module tb_top;
  localparam int RC_CYC = 6;
  logic                        mclk, rst_n, sleep_mode, conv_int_en, cmp_in;
  adcseq_pkg::adcseq_avs_req_t avs_req;
  adcseq_pkg::adcseq_avs_rsp_t avs_rsp;
  logic                        analog_on, ref_ext, sample_hold, done_set, wake_req;
  logic [2:0]                  channel_route;
  logic [9:0]                  sar_trial;
  logic [7:0]                  digin_off, pullup_off, ioc_off;
  logic [7:0][9:0]             levels;
  logic [31:0]                 rd;
  int                          failures, samples_checked, cyc, ndone, nwake, done_at;

  adcseq_top #(.RC_CYC(RC_CYC)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .sleep_mode(sleep_mode), .conv_int_en(conv_int_en), .cmp_in(cmp_in),
    .analog_on(analog_on), .ref_ext(ref_ext), .channel_route(channel_route),
    .sample_hold(sample_hold), .sar_trial(sar_trial), .digin_off(digin_off),
    .pullup_off(pullup_off), .ioc_off(ioc_off), .done_set(done_set), .wake_req(wake_req));

  adcseq_analog_model u_ana (
    .mclk(mclk), .channel_route(channel_route), .sample_hold(sample_hold),
    .analog_on(analog_on), .sar_trial(sar_trial), .levels(levels), .cmp_in(cmp_in));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (done_set === 1'b1) begin
      ndone <= ndone + 1;
      done_at <= cyc;
    end
    if (wake_req === 1'b1) nwake <= nwake + 1;
    if (cyc == 40000) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Bus access and checks
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_req.read <= ~wr;
    avs_req.write <= wr;
    avs_req.address <= a;
    avs_req.writedata <= {24'h000000, d};
    avs_req.byteenable <= 4'hF;
    do begin
      @(posedge mclk);
    end while (avs_rsp.waitrequest !== 1'b0);
    rd = avs_rsp.readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask

  task automatic wait_done(input int n0);
    int n;
    n = 0;
    while (ndone == n0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    `CHK(ndone, n0 + 1)
  endtask

  task automatic conv(input logic [2:0] ch, input logic [2:0] code, input logic just,
                      input int nd);
    logic [7:0] c;
    logic [9:0] r;
    int         n0, t0, dt;
    c = {just, 2'b00, ch, 2'b00};
    r = levels[ch];
    bus(1'b1, adcseq_pkg::IDX_CLKCFG, {1'b0, code, 4'h0});
    bus(1'b1, adcseq_pkg::IDX_CTRL, c);
    bus(1'b1, adcseq_pkg::IDX_CTRL, c | 8'h01);
    repeat (20) @(posedge mclk);
    n0 = ndone;
    bus(1'b1, adcseq_pkg::IDX_CTRL, c | 8'h03);
    t0 = cyc;
    rchk(adcseq_pkg::IDX_CTRL, c | 8'h03);
    wait_done(n0);
    dt = done_at - t0 - 11 * nd;
    `CHK(dt >= 0 && dt <= 8 + (code[1:0] == 2'h3 ? 4 : 0), 1'b1)
    rchk(adcseq_pkg::IDX_CTRL, c | 8'h01);
    if (nd >= 4) begin
      rchk(adcseq_pkg::IDX_RES_HI, just ? {6'h00, r[9:8]} : r[9:2]);
      rchk(adcseq_pkg::IDX_RES_LO, just ? r[7:0] : {r[1:0], 6'h00});
    end
    $display("conversion test done, clock code %0d", code);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i, k, n0, w0, t0;
    int codes[8];
    int nds[8];
    codes = '{0, 1, 2, 4, 5, 6, 3, 7};
    nds = '{2, 8, 32, 4, 16, 64, RC_CYC, RC_CYC};
    rst_n = 1'b0;
    sleep_mode = 1'b0;
    conv_int_en = 1'b0;
    avs_req = '0;
    failures = 0;
    samples_checked = 0;
    cyc = 0;
    ndone = 0;
    nwake = 0;
    done_at = 0;
    for (i = 0; i < 8; i++) levels[i] = 10'h1C3 + 10'(i * 83);
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rchk(adcseq_pkg::IDX_CTRL, 8'h00);
    rchk(adcseq_pkg::IDX_CLKCFG, 8'h00);
    rchk(adcseq_pkg::IDX_ANALOG_PIN_SELECT, 8'hFF);
    `CHK(digin_off, 8'hFF)
    `CHK(analog_on, 1'b0)
    bus(1'b1, adcseq_pkg::IDX_ANALOG_PIN_SELECT, 8'hA5);
    rchk(adcseq_pkg::IDX_ANALOG_PIN_SELECT, 8'hA5);
    `CHK({digin_off, pullup_off, ioc_off}, 24'hA5A5A5)
    bus(1'b1, adcseq_pkg::IDX_CLKCFG, 8'hFF);
    rchk(adcseq_pkg::IDX_CLKCFG, 8'h70);
    bus(1'b1, 8'h20, 8'h55);
    rchk(8'h20, 8'h00);
    bus(1'b1, adcseq_pkg::IDX_CTRL, 8'h7C);
    rchk(adcseq_pkg::IDX_CTRL, 8'h5C);
    `CHK({ref_ext, channel_route}, 4'hF)
    bus(1'b1, adcseq_pkg::IDX_CTRL, 8'h00);
    rchk(adcseq_pkg::IDX_CTRL, 8'h00);
    `CHK(ref_ext, 1'b0)
    $display("register test done");
    for (i = 0; i < 8; i++) conv(i[2:0], codes[i][2:0], i[0], nds[i]);
    // Abort in mid-conversion on the slowest divider
    rchk(adcseq_pkg::IDX_RES_HI, {6'h00, levels[7][9:8]});
    bus(1'b1, adcseq_pkg::IDX_CLKCFG, 8'h60);
    bus(1'b1, adcseq_pkg::IDX_CTRL, 8'h85);
    `CHK(analog_on, 1'b1)
    repeat (20) @(posedge mclk);
    bus(1'b1, adcseq_pkg::IDX_CTRL, 8'h87);
    repeat (100) @(posedge mclk);
    n0 = ndone;
    bus(1'b1, adcseq_pkg::IDX_CTRL, 8'h85);
    t0 = cyc;
    for (k = 0; k < 500 && sample_hold !== 1'b1; k++) @(posedge mclk);
    `CHK(cyc - t0 >= 124 && cyc - t0 <= 136, 1'b1)
    `CHK(ndone, n0)
    rchk(adcseq_pkg::IDX_RES_HI, {6'h00, levels[7][9:8]});
    rchk(adcseq_pkg::IDX_RES_LO, levels[7][7:0]);
    $display("abort test done");
    bus(1'b1, adcseq_pkg::IDX_CLKCFG, 8'h10);
    bus(1'b1, adcseq_pkg::IDX_CTRL, 8'h87);
    sleep_mode <= 1'b1;
    repeat (200) @(posedge mclk);
    `CHK({analog_on, ndone}, {1'b0, n0})
    rchk(adcseq_pkg::IDX_CTRL, 8'h85);
    sleep_mode <= 1'b0;
    bus(1'b1, adcseq_pkg::IDX_CLKCFG, 8'h30);
    for (k = 0; k < 2; k++) begin
      repeat (20) @(posedge mclk);
      conv_int_en <= (k == 0);
      n0 = ndone;
      w0 = nwake;
      bus(1'b1, adcseq_pkg::IDX_CTRL, 8'h87);
      sleep_mode <= 1'b1;
      wait_done(n0);
      repeat (3) @(posedge mclk);
      `CHK(nwake, w0 + (k == 0 ? 1 : 0))
      `CHK(analog_on, (k == 0))
      rchk(adcseq_pkg::IDX_CTRL, 8'h85);
      rchk(adcseq_pkg::IDX_RES_LO, levels[1][7:0]);
      sleep_mode <= 1'b0;
    end
    $display("sleep test done");
    repeat (20) @(posedge mclk);
    n0 = ndone;
    bus(1'b1, adcseq_pkg::IDX_CTRL, 8'h87);
    repeat (10) @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    `CHK({analog_on, ndone}, {1'b0, n0})
    rchk(adcseq_pkg::IDX_CTRL, 8'h00);
    rchk(adcseq_pkg::IDX_CLKCFG, 8'h00);
    rchk(adcseq_pkg::IDX_RES_HI, {6'h00, levels[1][9:8]});
    rchk(adcseq_pkg::IDX_RES_LO, levels[1][7:0]);
    $display("reset test done");
    summarize();
  end
endmodule

`default_nettype wire
